// ==== design/bps_map.vh ====
`ifndef BPS_MAP_VH
`define BPS_MAP_VH

// clock rate in cycles per millisecond (25 MHz)
`define BPS_CLK_KHZ          25000

// times in milliseconds
`define BPS_PURGE_MS         15000
`define BPS_POS_PROOF_MS     10000
`define BPS_AIRFLOW_PROOF_MS 10000

// state codes
`define BPS_ST_WAITING       3'h0
`define BPS_ST_STARTUP       3'h1
`define BPS_ST_REQ_PURGE     3'h2
`define BPS_ST_PROVE_AIR     3'h3
`define BPS_ST_PRE_PURGE     3'h4
`define BPS_ST_REQ_PILOT     3'h5
`define BPS_ST_IGNITION      3'h6
`define BPS_ST_LOCKOUT       3'h7

// positioner target codes, one per air-ratio channel
`define BPS_POS_NONE         2'h0
`define BPS_POS_PURGE        2'h1
`define BPS_POS_PILOT        2'h2

// lockout cause codes
`define BPS_CAUSE_NONE       3'h0
`define BPS_CAUSE_ALARM      3'h1
`define BPS_CAUSE_STOP       3'h2
`define BPS_CAUSE_AIR_STUCK  3'h3
`define BPS_CAUSE_PURGE_POS  3'h4
`define BPS_CAUSE_AIRFLOW    3'h5
`define BPS_CAUSE_PILOT_POS  3'h6

`endif

// ==== design/bps_sequencer.v ====
`timescale 1ns/100ps
`include "bps_map.vh"
module bps_sequencer #(
    parameter CHANNELS        = 2,
    parameter PURGE_CYCLES    = `BPS_PURGE_MS * `BPS_CLK_KHZ,
    parameter POS_CYCLES      = `BPS_POS_PROOF_MS * `BPS_CLK_KHZ,
    parameter AIRFLOW_CYCLES  = `BPS_AIRFLOW_PROOF_MS * `BPS_CLK_KHZ
) (
    // clock, reset, enable
    input  wire                    ref_clk,
    input  wire                    rst,
    input  wire                    clk_en,
    // configuration and conditions (asynchronous pins)
    input  wire                    air_ratio_enable_setting,
    input  wire                    alarm_in,
    input  wire                    wait_in,
    input  wire                    user_stop,
    input  wire                    lockout_reset,
    input  wire                    ignition_done,
    // field proofs (asynchronous pins)
    input  wire                    airflow_sensed,
    input  wire [CHANNELS-1:0]     purge_pos_proven,
    input  wire [CHANNELS-1:0]     pilot_pos_proven,
    // fan and positioners
    output reg                     fan_output_ff,
    output reg  [2*CHANNELS-1:0]   air_ratio_channel_ff,
    // safety outputs
    output reg                     pilot_valve_ff,
    output reg                     main_valve_one_ff,
    output reg                     main_valve_two_ff,
    output reg                     pilot_card_valve_ff,
    output reg                     coil_ff,
    output reg                     ignition_enable_ff,
    // status
    output reg  [2:0]              state_ff,
    output reg                     lockout_ff,
    output reg  [2:0]              lockout_cause_ff
);

    localparam SYNC_W = 6 + 1 + 2 * CHANNELS;
    // wait reads active until real pin values arrive, so reset gives no false start
    localparam [SYNC_W-1:0] SYNC_RST = {2'b00, 1'b1, {(SYNC_W-3){1'b0}}};

    localparam [2:0] ST_WAITING   = `BPS_ST_WAITING;
    localparam [2:0] ST_STARTUP   = `BPS_ST_STARTUP;
    localparam [2:0] ST_REQ_PURGE = `BPS_ST_REQ_PURGE;
    localparam [2:0] ST_PROVE_AIR = `BPS_ST_PROVE_AIR;
    localparam [2:0] ST_PRE_PURGE = `BPS_ST_PRE_PURGE;
    localparam [2:0] ST_REQ_PILOT = `BPS_ST_REQ_PILOT;
    localparam [2:0] ST_IGNITION  = `BPS_ST_IGNITION;
    localparam [2:0] ST_LOCKOUT   = `BPS_ST_LOCKOUT;

    localparam [31:0] PURGE_LIM   = PURGE_CYCLES;
    localparam [31:0] POS_LIM     = POS_CYCLES;
    localparam [31:0] AIRFLOW_LIM = AIRFLOW_CYCLES;

    // input synchroniser
    reg  [SYNC_W-1:0]      sync1_ff;
    reg  [SYNC_W-1:0]      sync2_ff;
    wire [SYNC_W-1:0]      pins;

    assign pins = {air_ratio_enable_setting, alarm_in, wait_in, user_stop,
                   lockout_reset, ignition_done, airflow_sensed,
                   purge_pos_proven, pilot_pos_proven};

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
        end else if (clk_en) begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
        end
    end

    wire                enable_s    = sync2_ff[SYNC_W-1];
    wire                alarm_s     = sync2_ff[SYNC_W-2];
    wire                wait_s      = sync2_ff[SYNC_W-3];
    wire                stop_s      = sync2_ff[SYNC_W-4];
    wire                reset_s     = sync2_ff[SYNC_W-5];
    wire                ign_done_s  = sync2_ff[SYNC_W-6];
    wire                airflow_s   = sync2_ff[SYNC_W-7];
    wire [CHANNELS-1:0] purge_ok_v  = sync2_ff[2*CHANNELS-1:CHANNELS];
    wire [CHANNELS-1:0] pilot_ok_v  = sync2_ff[CHANNELS-1:0];
    wire                purge_ok    = &purge_ok_v;
    wire                pilot_ok    = &pilot_ok_v;

    // state timer, restarted on every state change
    reg  [2:0]  nxt_state;
    reg  [2:0]  nxt_cause;
    reg  [31:0] timer_limit;
    wire        timer_expired;
    wire        state_change = (nxt_state != state_ff);

    always @* begin
        case (state_ff)
            ST_REQ_PURGE: timer_limit = POS_LIM;
            ST_REQ_PILOT: timer_limit = POS_LIM;
            ST_PROVE_AIR: timer_limit = AIRFLOW_LIM;
            ST_PRE_PURGE: timer_limit = PURGE_LIM;
            default:      timer_limit = POS_LIM;
        endcase
    end

    bps_timer #(
        .WIDTH      (32)
    ) u_timer (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .restart    (state_change),
        .limit      (timer_limit),
        .expired_ff (timer_expired)
    );

    // next state
    always @* begin
        nxt_state = state_ff;
        nxt_cause = lockout_cause_ff;
        if (state_ff != ST_LOCKOUT && (alarm_s || stop_s)) begin
            nxt_state = ST_LOCKOUT;
            nxt_cause = alarm_s ? `BPS_CAUSE_ALARM : `BPS_CAUSE_STOP;
        end else if (state_ff != ST_LOCKOUT && state_ff != ST_WAITING && wait_s) begin
            nxt_state = ST_WAITING;
        end else begin
            case (state_ff)
                ST_WAITING: begin
                    if (!wait_s) begin
                        if (enable_s) begin
                            nxt_state = ST_STARTUP;
                        end else begin
                            nxt_state = ST_IGNITION;
                        end
                    end
                end
                ST_STARTUP: begin
                    if (airflow_s) begin
                        nxt_state = ST_LOCKOUT;
                        nxt_cause = `BPS_CAUSE_AIR_STUCK;
                    end else begin
                        nxt_state = ST_REQ_PURGE;
                    end
                end
                ST_REQ_PURGE: begin
                    if (purge_ok) begin
                        nxt_state = ST_PROVE_AIR;
                    end else if (timer_expired) begin
                        nxt_state = ST_LOCKOUT;
                        nxt_cause = `BPS_CAUSE_PURGE_POS;
                    end
                end
                ST_PROVE_AIR: begin
                    if (!purge_ok) begin
                        nxt_state = ST_LOCKOUT;
                        nxt_cause = `BPS_CAUSE_PURGE_POS;
                    end else if (airflow_s) begin
                        nxt_state = ST_PRE_PURGE;
                    end else if (timer_expired) begin
                        nxt_state = ST_LOCKOUT;
                        nxt_cause = `BPS_CAUSE_AIRFLOW;
                    end
                end
                ST_PRE_PURGE: begin
                    if (!airflow_s) begin
                        nxt_state = ST_LOCKOUT;
                        nxt_cause = `BPS_CAUSE_AIRFLOW;
                    end else if (!purge_ok) begin
                        nxt_state = ST_LOCKOUT;
                        nxt_cause = `BPS_CAUSE_PURGE_POS;
                    end else if (timer_expired) begin
                        nxt_state = enable_s ? ST_REQ_PILOT : ST_IGNITION;
                    end
                end
                ST_REQ_PILOT: begin
                    if (pilot_ok) begin
                        nxt_state = ST_IGNITION;
                    end else if (timer_expired) begin
                        nxt_state = ST_LOCKOUT;
                        nxt_cause = `BPS_CAUSE_PILOT_POS;
                    end
                end
                ST_IGNITION: begin
                    if (ign_done_s) begin
                        nxt_state = ST_WAITING;
                    end
                end
                ST_LOCKOUT: begin
                    if (reset_s && !alarm_s && !stop_s) begin
                        nxt_state = ST_WAITING;
                        nxt_cause = `BPS_CAUSE_NONE;
                    end
                end
                default: begin
                    nxt_state = ST_LOCKOUT;
                    nxt_cause = `BPS_CAUSE_NONE;
                end
            endcase
        end
    end

    // output decode from the next state so outputs move with the state register
    reg                   nxt_fan;
    reg  [1:0]            nxt_target;
    reg                   nxt_pilot_fuel;
    reg                   nxt_ign;
    integer               ch;

    always @* begin
        nxt_fan        = 1'b0;
        nxt_target     = `BPS_POS_NONE;
        nxt_pilot_fuel = 1'b0;
        nxt_ign        = 1'b0;
        case (nxt_state)
            ST_REQ_PURGE: begin
                nxt_target = `BPS_POS_PURGE;
            end
            ST_PROVE_AIR: begin
                nxt_fan    = 1'b1;
                nxt_target = `BPS_POS_PURGE;
            end
            ST_PRE_PURGE: begin
                nxt_fan    = 1'b1;
                nxt_target = `BPS_POS_PURGE;
            end
            ST_REQ_PILOT: begin
                nxt_fan    = 1'b1;
                nxt_target = `BPS_POS_PILOT;
            end
            ST_IGNITION: begin
                nxt_pilot_fuel = 1'b1;
                nxt_ign        = 1'b1;
            end
            default: begin
                nxt_fan = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff             <= ST_WAITING;
            lockout_cause_ff     <= `BPS_CAUSE_NONE;
            lockout_ff           <= 1'b0;
            fan_output_ff        <= 1'b0;
            air_ratio_channel_ff <= {(2*CHANNELS){1'b0}};
            pilot_valve_ff       <= 1'b0;
            main_valve_one_ff    <= 1'b0;
            main_valve_two_ff    <= 1'b0;
            pilot_card_valve_ff  <= 1'b0;
            coil_ff              <= 1'b0;
            ignition_enable_ff   <= 1'b0;
        end else if (clk_en) begin
            state_ff             <= nxt_state;
            lockout_cause_ff     <= nxt_cause;
            lockout_ff           <= (nxt_state == ST_LOCKOUT);
            fan_output_ff        <= nxt_fan;
            for (ch = 0; ch < CHANNELS; ch = ch + 1) begin
                air_ratio_channel_ff[2*ch +: 2] <= nxt_target;
            end
            pilot_valve_ff       <= nxt_pilot_fuel;
            main_valve_one_ff    <= 1'b0;
            main_valve_two_ff    <= 1'b0;
            pilot_card_valve_ff  <= nxt_pilot_fuel;
            coil_ff              <= nxt_ign;
            ignition_enable_ff   <= nxt_ign;
        end
    end

endmodule

// ==== design/bps_timer.v ====
`timescale 1ns/100ps
module bps_timer #(
    parameter WIDTH = 32
) (
    // clock and reset
    input  wire             ref_clk,
    input  wire             rst,
    input  wire             clk_en,
    // control
    input  wire             restart,
    input  wire [WIDTH-1:0] limit,
    // status
    output reg              expired_ff
);

    reg  [WIDTH-1:0] count_ff;
    reg  [WIDTH-1:0] nxt_count;
    reg              nxt_expired;

    always @* begin
        nxt_count   = count_ff;
        nxt_expired = expired_ff;
        if (restart) begin
            nxt_count   = {WIDTH{1'b0}};
            nxt_expired = 1'b0;
        end else if (!expired_ff) begin
            nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
            if (count_ff + {{(WIDTH-1){1'b0}}, 1'b1} >= limit) begin
                nxt_expired = 1'b1;
            end
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_ff   <= {WIDTH{1'b0}};
            expired_ff <= 1'b0;
        end else if (clk_en) begin
            count_ff   <= nxt_count;
            expired_ff <= nxt_expired;
        end
    end

endmodule

// ==== test/bps_field.sv ====
`timescale 1ns/100ps
module bps_field (
    // clock
    input  wire       ref_clk,
    // commands from the sequencer
    input  wire       fan_output_ff,
    input  wire [3:0] air_ratio_channel_ff,
    // response lag in cycles, injected fault
    input  wire [2:0] lag,
    input  wire [2:0] fault,
    // field proofs
    output reg        airflow_sensed,
    output reg  [1:0] purge_pos_proven,
    output reg  [1:0] pilot_pos_proven
);
    reg [3:0] tgt_ff  = 4'h0;
    reg [3:0] move_ff = 4'h0;
    reg [3:0] spin_ff = 4'h0;
    integer   c;
    // positioners travel again on every new target, fan spins up from rest
    always @(posedge ref_clk) begin
        tgt_ff  <= air_ratio_channel_ff;
        move_ff <= (air_ratio_channel_ff != tgt_ff) ? 4'h0 : move_ff + {3'h0, move_ff != 4'hf};
        spin_ff <= fan_output_ff ? spin_ff + {3'h0, spin_ff != 4'hf} : 4'h0;
    end
    // fault 1 switch stuck made, 2 no air, 3 channel 0 never at purge, 4 never at pilot
    always @* begin
        airflow_sensed = fault == 3'h1 || (spin_ff >= {1'b0, lag} && fault != 3'h2);
        for (c = 0; c < 2; c = c + 1) begin
            purge_pos_proven[c] = move_ff >= {1'b0, lag} && tgt_ff == air_ratio_channel_ff &&
                air_ratio_channel_ff[2*c +: 2] == 2'h1 && !(fault == 3'h3 && c == 0);
            pilot_pos_proven[c] = move_ff >= {1'b0, lag} && tgt_ff == air_ratio_channel_ff &&
                air_ratio_channel_ff[2*c +: 2] == 2'h2 && fault != 3'h4;
        end
    end
endmodule

// ==== test/bps_sequencer_sva.sv ====
`timescale 1ns/100ps
module bps_sequencer_sva #(
    parameter CHANNELS     = 2,
    parameter PURGE_CYCLES = 20
) (
    // clock and reset
    input wire                  ref_clk,
    input wire                  rst,
    // conditions
    input wire                  air_ratio_enable_setting,
    input wire                  alarm_in,
    input wire                  wait_in,
    input wire                  user_stop,
    input wire                  airflow_sensed,
    input wire [CHANNELS-1:0]   purge_pos_proven,
    // outputs
    input wire                  fan_output_ff,
    input wire [2*CHANNELS-1:0] air_ratio_channel_ff,
    input wire                  pilot_valve_ff,
    input wire                  main_valve_one_ff,
    input wire                  main_valve_two_ff,
    input wire                  pilot_card_valve_ff,
    input wire                  coil_ff,
    input wire                  ignition_enable_ff,
    input wire [2:0]            state_ff,
    input wire                  lockout_ff,
    input wire [2:0]            lockout_cause_ff
);
    default clocking dflt @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire [5:0]  safety = {pilot_valve_ff, main_valve_one_ff, main_valve_two_ff,
                          pilot_card_valve_ff, coil_ff, ignition_enable_ff};
    wire        run_st = state_ff >= 3'h1 && state_ff <= 3'h5;
    reg  [31:0] pp_cnt_ff;
    // consecutive cycles spent in pre-purge
    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            pp_cnt_ff <= 32'h0000_0000;
        else
            pp_cnt_ff <= (state_ff == 3'h4) ? pp_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
    end
    chk_safe_off : assert property (
        state_ff != 3'h6 |-> safety == 6'h00)
        else $error("safety output on outside ignition");
    chk_ignite_outs : assert property (
        state_ff == 3'h6 |-> safety == 6'h27)
        else $error("ignition outputs not as commanded");
    chk_lock_flag : assert property (
        lockout_ff == (state_ff == 3'h7))
        else $error("lockout flag disagrees with state");
    chk_startup_entry : assert property (
        (state_ff == 3'h0 ##1 state_ff == 3'h1) |->
        $past(air_ratio_enable_setting, 3) && !$past(alarm_in, 3) && !$past(wait_in, 3))
        else $error("startup checks entered without permission");
    chk_stuck_air : assert property (
        state_ff == 3'h1 && $past(airflow_sensed, 2) &&
        !$past(alarm_in, 2) && !$past(user_stop, 2) && !$past(wait_in, 2)
        |=> state_ff == 3'h7 && lockout_cause_ff == 3'h3) else $error("stuck airflow missed");
    chk_startup_pass : assert property (
        state_ff == 3'h1 && !$past(airflow_sensed, 2) &&
        !$past(alarm_in, 2) && !$past(user_stop, 2) && !$past(wait_in, 2)
        |=> state_ff == 3'h2) else $error("startup checks did not advance");
    chk_halt_lock : assert property (
        run_st && ($past(alarm_in, 2) || $past(user_stop, 2))
        |=> state_ff == 3'h7 && lockout_cause_ff == ($past(alarm_in, 3) ? 3'h1 : 3'h2))
        else $error("alarm or stop did not lock out");
    chk_wait_return : assert property (
        run_st && $past(wait_in, 2) && !$past(alarm_in, 2) && !$past(user_stop, 2)
        |=> state_ff == 3'h0) else $error("wait did not return to waiting");
    chk_purge_target : assert property (
        state_ff inside {3'h2, 3'h3, 3'h4} |-> air_ratio_channel_ff == {CHANNELS{2'h1}})
        else $error("channels not at purge");
    chk_fan_on : assert property (
        state_ff inside {3'h3, 3'h4, 3'h5} |-> fan_output_ff)
        else $error("fan off during purge sequence");
    chk_pilot_target : assert property (
        state_ff == 3'h5 |-> air_ratio_channel_ff == {CHANNELS{2'h2}})
        else $error("channels not at pilot");
    chk_purge_loss : assert property (
        state_ff == 3'h4 && (!$past(airflow_sensed, 2) || !(&$past(purge_pos_proven, 2))) &&
        !$past(alarm_in, 2) && !$past(user_stop, 2) && !$past(wait_in, 2)
        |=> state_ff == 3'h7) else $error("purge loss not locked out");
    chk_purge_time : assert property (
        (state_ff == 3'h4 ##1 state_ff inside {3'h5, 3'h6}) |-> pp_cnt_ff >= PURGE_CYCLES)
        else $error("pre-purge ended early");
    cover property (state_ff == 3'h5 ##1 state_ff == 3'h6);
    cover property (state_ff == 3'h4 ##1 state_ff == 3'h7);
    cover property (state_ff == 3'h1 ##1 state_ff == 3'h7);
endmodule
bind bps_sequencer bps_sequencer_sva #(.CHANNELS(CHANNELS), .PURGE_CYCLES(PURGE_CYCLES)) u_sva (
    .ref_clk, .rst, .air_ratio_enable_setting, .alarm_in, .wait_in, .user_stop,
    .airflow_sensed, .purge_pos_proven, .fan_output_ff, .air_ratio_channel_ff,
    .pilot_valve_ff, .main_valve_one_ff, .main_valve_two_ff, .pilot_card_valve_ff,
    .coil_ff, .ignition_enable_ff, .state_ff, .lockout_ff, .lockout_cause_ff);

// ==== test/burner_purge_sequencer_test.sv ====
`timescale 1ns/100ps
module burner_purge_sequencer_test;
    localparam [11:0] FLT = {3'h4, 3'h2, 3'h3, 3'h1};
    localparam [11:0] DEP = {3'h5, 3'h3, 3'h2, 3'h1};
    localparam [17:0] CAU = {3'h4, 3'h5, 3'h6, 3'h5, 3'h4, 3'h3};
    reg        ref_clk, rst, clk_en, air_ratio_enable_setting, alarm_in, wait_in;
    reg        user_stop, lockout_reset, ignition_done;
    reg  [2:0] lag, fault, last_st;
    wire       airflow_sensed, fan_output_ff;
    wire [1:0] purge_pos_proven, pilot_pos_proven;
    wire [3:0] air_ratio_channel_ff;
    wire [2:0] state_ff, lockout_cause_ff;
    wire [5:0] obs = {state_ff, lockout_cause_ff};
    reg  [5:0] exp_q[$];
    integer    n_fail, total_checks, i, n, k;

    bps_sequencer #(.PURGE_CYCLES(20), .POS_CYCLES(16), .AIRFLOW_CYCLES(16)) i_dut (
        .ref_clk, .rst, .clk_en, .air_ratio_enable_setting, .alarm_in, .wait_in, .user_stop,
        .lockout_reset, .ignition_done, .airflow_sensed, .purge_pos_proven, .pilot_pos_proven,
        .fan_output_ff, .air_ratio_channel_ff, .pilot_valve_ff(), .main_valve_one_ff(),
        .main_valve_two_ff(), .pilot_card_valve_ff(), .coil_ff(), .ignition_enable_ff(),
        .state_ff, .lockout_ff(), .lockout_cause_ff);
    bps_field i_field (.ref_clk, .fan_output_ff, .air_ratio_channel_ff, .lag, .fault,
        .airflow_sensed, .purge_pos_proven, .pilot_pos_proven);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task check(input [5:0] seen, input [5:0] want);
        total_checks = total_checks + 1;
        if (seen !== want) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task note(input [2:0] s, input [2:0] c);
        exp_q.push_back({s, c});
    endtask
    task climb(input [2:0] s);
        integer j;
        for (j = 1; j <= s; j = j + 1)
            note(j[2:0], 3'h0);
    endtask
    task drain;
        for (k = 0; k < 300 && exp_q.size() > 0; k = k + 1)
            @(posedge ref_clk);
        if (exp_q.size() > 0) begin
            n_fail = n_fail + 1;
            conclude;
        end
    endtask
    task start(input [2:0] l);
        repeat ($urandom_range(4, 1)) @(posedge ref_clk);
        lag     <= l;
        wait_in <= 1'b0;
    endtask
    task recover;
        alarm_in      <= 1'b0;
        user_stop     <= 1'b0;
        wait_in       <= 1'b1;
        fault         <= 3'h0;
        lockout_reset <= 1'b1;
        note(3'h0, 3'h0);
        drain;
        lockout_reset <= 1'b0;
    endtask

    // each new state and cause is compared with the oldest note
    always @(posedge ref_clk) begin
        if (!rst && state_ff !== last_st) begin
            if (exp_q.size() == 0)
                check(obs, 6'h3f);
            else
                check(obs, exp_q.pop_front());
            last_st = state_ff;
        end
    end

    initial begin
        k = $urandom(32'hcfa1_99aa);
        n_fail = 0;
        total_checks = 0;
        last_st = 3'h0;
        {rst, clk_en, air_ratio_enable_setting, wait_in} = 4'hf;
        {alarm_in, user_stop, lockout_reset, ignition_done} = 4'h0;
        lag = 3'h1;
        fault = 3'h0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        for (i = 0; i < 2; i = i + 1) begin
            start($urandom_range(6, 1));
            climb(3'h4);
            drain;
            air_ratio_enable_setting <= (i == 1);
            // stall in pre-purge: any state change while frozen is unexpected
            clk_en <= 1'b0;
            repeat (5) @(posedge ref_clk);
            clk_en <= 1'b1;
            if (i == 1)
                note(3'h5, 3'h0);
            note(3'h6, 3'h0);
            drain;
            wait_in <= 1'b1;
            air_ratio_enable_setting <= 1'b1;
            ignition_done <= (i == 0);
            note(3'h0, 3'h0);
            drain;
            ignition_done <= 1'b0;
        end
        start(3'h1);
        air_ratio_enable_setting <= 1'b0;
        note(3'h6, 3'h0);
        drain;
        wait_in <= 1'b1;
        air_ratio_enable_setting <= 1'b1;
        note(3'h0, 3'h0);
        drain;
        for (n = 0; n < 6; n = n + 1) begin
            start($urandom_range(6, 1));
            fault <= (n < 4) ? FLT[3*n +: 3] : 3'h0;
            climb((n < 4) ? DEP[3*n +: 3] : 3'h4);
            if (n >= 4) begin
                drain;
                fault <= (n == 4) ? 3'h2 : 3'h3;
            end
            note(3'h7, CAU[3*n +: 3]);
            drain;
            recover;
        end
        start(3'h6);
        @(posedge ref_clk);
        user_stop <= 1'b1;
        note(3'h1, 3'h0);
        note(3'h7, 3'h2);
        drain;
        recover;
        for (n = 2; n <= 5; n = n + 1) begin
            for (i = 0; i < 3; i = i + 1) begin
                start(3'h6);
                climb(n[2:0]);
                for (k = 0; k < 200 && state_ff !== n[2:0]; k = k + 1)
                    @(posedge ref_clk);
                if (k == 200) begin
                    n_fail = n_fail + 1;
                    conclude;
                end
                if (i == 0)
                    alarm_in <= 1'b1;
                else if (i == 1)
                    user_stop <= 1'b1;
                else
                    wait_in <= 1'b1;
                note((i == 2) ? 3'h0 : 3'h7, (i == 2) ? 3'h0 : i[2:0] + 3'h1);
                drain;
                if (i < 2)
                    recover;
            end
        end
        repeat (5) @(posedge ref_clk);
        conclude;
    end
endmodule
